//--- design/bmw_pkg.sv
// Constants, field layouts and helpers for the bridge memory window registers.
// How it works
// - Secondary status error bits always read zero.
// - Select-timing field of secondary status reads 00.
// - Back-to-back and fast-bus capability bits read zero.
// - Status reserved bits zero; register ignores writes.
// - Writable 12-bit memory base gives address 31:20.
// - Writable 12-bit memory limit, low bits ones.
// - Base and limit low nibbles read zero.
// - Memory window decides downstream forwarding.
// - Writable 12-bit prefetch base gives address 31:20.
// - Prefetch base is 64 bits with upper register.
// - Prefetch base low nibble reads 64-bit code 1.
// - Prefetch limit field at 26h, low bits ones.
// - Writable 32-bit prefetch upper base at 28h.
package bmw_pkg;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] SEC_STATUS_OFS    = 8'h1E;
  localparam logic [7:0] MEM_BASE_OFS      = 8'h20;
  localparam logic [7:0] MEM_LIMIT_OFS     = 8'h22;
  localparam logic [7:0] PF_BASE_OFS       = 8'h24;
  localparam logic [7:0] PF_LIMIT_OFS      = 8'h26;
  localparam logic [7:0] PF_BASE_UPPER_OFS = 8'h28;

  // Dword indices of the configuration accesses that reach these registers.
  localparam logic [5:0] DW_STATUS   = SEC_STATUS_OFS[7:2];
  localparam logic [5:0] DW_MEM      = MEM_BASE_OFS[7:2];
  localparam logic [5:0] DW_PF       = PF_BASE_OFS[7:2];
  localparam logic [5:0] DW_PF_UPPER = PF_BASE_UPPER_OFS[7:2];

  // ==========================================================================
  // Field layout of the window registers.
  localparam int         FIELD_LSB  = 4;
  localparam int         FIELD_W    = 12;
  localparam logic [3:0] LOW_NIBBLE = 4'h0;

  // Address bits below the window granule.
  localparam logic [19:0] LOW_ZERO = 20'h00000;
  localparam logic [19:0] LOW_ONES = 20'hFFFFF;

  // ==========================================================================
  // Values after reset.
  localparam logic [11:0] FIELD_RST         = 12'h000;
  localparam logic [31:0] PF_BASE_UPPER_RST = 32'h00000000;
  // The prefetch limit upper word is not held here and counts as zero.
  localparam logic [31:0] PF_LIMIT_UPPER    = 32'h00000000;
  localparam logic [3:0]  WIDE_ADDRESS_CODE = 4'h1;

  // ==========================================================================
  // Fixed secondary status fields.
  localparam logic       PARITY_ERROR_SEEN       = 1'h0;
  localparam logic       SYSTEM_ERROR_RECEIVED   = 1'h0;
  localparam logic       MASTER_ABORT_RECEIVED   = 1'h0;
  localparam logic       TARGET_ABORT_RECEIVED   = 1'h0;
  localparam logic       TARGET_ABORT_SIGNALLED  = 1'h0;
  localparam logic [1:0] SELECT_TIMING           = 2'h0;
  localparam logic       MASTER_DATA_PARITY_FLAG = 1'h0;
  localparam logic       BACK_TO_BACK_CAPABLE    = 1'h0;
  localparam logic       FAST_BUS_CAPABLE        = 1'h0;
  localparam logic       STATUS_RSVD_BIT         = 1'h0;
  localparam logic [4:0] STATUS_RSVD_LOW         = 5'h00;

  // Merges a 16-bit half word under its two byte enables.
  function automatic logic [15:0] bmw_merge16(input logic [15:0] old_v,
                                              input logic [15:0] new_v,
                                              input logic [1:0]  be);
    bmw_merge16 = {be[1] ? new_v[15:8] : old_v[15:8],
                   be[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction

endpackage

//--- design/bmw_regs.sv
// Memory window configuration registers and forwarding decision of the bridge.
`timescale 1ns/10ps
module bmw_regs
  import bmw_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Configuration access request.
  input  wire logic        cfg_valid_i,
  input  wire logic        cfg_write_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [3:0]  cfg_byte_en_i,
  input  wire logic [31:0] cfg_wdata_i,
  // Configuration access answer.
  output logic             cfg_ack_o,
  output logic [31:0]      cfg_rdata_o,
  // Memory transaction lookup.
  input  wire logic        fwd_valid_i,
  input  wire logic [63:0] fwd_addr_i,
  output logic             fwd_done_o,
  output logic             fwd_downstream_o,
  output logic             fwd_prefetch_o
);

  // ==========================================================================
  // Storage and decode.
  logic [11:0] window_bottom_field;
  logic [11:0] window_top_field;
  logic [11:0] prefetch_bottom_field;
  logic [11:0] prefetch_top_field;
  logic [31:0] prefetch_bottom_upper;
  logic [15:0] secondary_bus_status;
  logic [15:0] memory_window_base;
  logic [15:0] memory_window_limit;
  logic [15:0] prefetch_window_base;
  logic [15:0] prefetch_window_limit;
  logic [15:0] next_mem_base;
  logic [15:0] next_mem_limit;
  logic [15:0] next_pf_base;
  logic [15:0] next_pf_limit;
  logic [31:0] next_rdata;
  logic        cfg_wr;
  logic [5:0]  cfg_dw;
  logic        mem_hit;
  logic        pf_hit;

  assign cfg_wr = cfg_valid_i && cfg_write_i;
  assign cfg_dw = cfg_addr_i[7:2];

  // The status word is built only from fixed fields, so writes cannot touch it.
  assign secondary_bus_status = {PARITY_ERROR_SEEN, SYSTEM_ERROR_RECEIVED,
                                 MASTER_ABORT_RECEIVED, TARGET_ABORT_RECEIVED,
                                 TARGET_ABORT_SIGNALLED,
                                 SELECT_TIMING,
                                 MASTER_DATA_PARITY_FLAG,
                                 BACK_TO_BACK_CAPABLE,
                                 STATUS_RSVD_BIT,
                                 FAST_BUS_CAPABLE,
                                 STATUS_RSVD_LOW};

  // Read views of the window registers with their fixed low nibbles.
  assign memory_window_base    = {window_bottom_field, LOW_NIBBLE};
  assign memory_window_limit   = {window_top_field, LOW_NIBBLE};
  assign prefetch_window_base  = {prefetch_bottom_field, WIDE_ADDRESS_CODE};
  assign prefetch_window_limit = {prefetch_top_field, WIDE_ADDRESS_CODE};

  // Byte-merged write values; the low nibble is dropped when stored.
  assign next_mem_base  = bmw_merge16(memory_window_base, cfg_wdata_i[15:0], cfg_byte_en_i[1:0]);
  assign next_mem_limit = bmw_merge16(memory_window_limit, cfg_wdata_i[31:16],
                                      cfg_byte_en_i[3:2]);
  assign next_pf_base   = bmw_merge16(prefetch_window_base, cfg_wdata_i[15:0],
                                      cfg_byte_en_i[1:0]);
  assign next_pf_limit  = bmw_merge16(prefetch_window_limit, cfg_wdata_i[31:16],
                                      cfg_byte_en_i[3:2]);

  // ==========================================================================
  // Register writes.

  // Memory window base and limit share one dword.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      window_bottom_field <= FIELD_RST;
      window_top_field    <= FIELD_RST;
    end else if (cfg_wr && cfg_dw == DW_MEM) begin
      window_bottom_field <= next_mem_base[15:FIELD_LSB];
      window_top_field    <= next_mem_limit[15:FIELD_LSB];
    end
  end

  // Prefetch window base and limit share the next dword.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prefetch_bottom_field <= FIELD_RST;
      prefetch_top_field    <= FIELD_RST;
    end else if (cfg_wr && cfg_dw == DW_PF) begin
      prefetch_bottom_field <= next_pf_base[15:FIELD_LSB];
      prefetch_top_field    <= next_pf_limit[15:FIELD_LSB];
    end
  end

  // Upper 32 bits of the prefetch base, written byte by byte.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prefetch_bottom_upper <= PF_BASE_UPPER_RST;
    end else if (cfg_wr && cfg_dw == DW_PF_UPPER) begin
      prefetch_bottom_upper <= {bmw_merge16(prefetch_bottom_upper[31:16], cfg_wdata_i[31:16],
                                            cfg_byte_en_i[3:2]),
                                bmw_merge16(prefetch_bottom_upper[15:0], cfg_wdata_i[15:0],
                                            cfg_byte_en_i[1:0])};
    end
  end

  // ==========================================================================
  // Register reads.

  // Read mux; unmapped dwords and halves read zero.
  always_comb begin
    next_rdata = 32'h00000000;
    unique case (cfg_dw)
      DW_STATUS:   next_rdata = {secondary_bus_status, 16'h0000};
      DW_MEM:      next_rdata = {memory_window_limit, memory_window_base};
      DW_PF:       next_rdata = {prefetch_window_limit, prefetch_window_base};
      DW_PF_UPPER: next_rdata = prefetch_bottom_upper;
      default:     next_rdata = 32'h00000000;
    endcase
  end

  // Every access is answered one cycle later; writes return zero data.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg_ack_o   <= 1'b0;
      cfg_rdata_o <= 32'h00000000;
    end else begin
      cfg_ack_o   <= cfg_valid_i;
      cfg_rdata_o <= (cfg_valid_i && !cfg_write_i) ? next_rdata : 32'h00000000;
    end
  end

  // ==========================================================================
  // Forwarding decision.

  // Non-prefetchable window is 32-bit, so the upper address word must be zero.
  bmw_window_match u_mem_window (
    .base_i  ({32'h00000000, window_bottom_field, LOW_ZERO}),
    .limit_i ({32'h00000000, window_top_field, LOW_ONES}),
    .addr_i  (fwd_addr_i),
    .hit_o   (mem_hit)
  );

  // Prefetch window uses the 64-bit base.
  bmw_window_match u_pf_window (
    .base_i  ({prefetch_bottom_upper, prefetch_bottom_field, LOW_ZERO}),
    .limit_i ({PF_LIMIT_UPPER, prefetch_top_field, LOW_ONES}),
    .addr_i  (fwd_addr_i),
    .hit_o   (pf_hit)
  );

  // A lookup is answered one cycle later with the registered decision.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fwd_done_o       <= 1'b0;
      fwd_downstream_o <= 1'b0;
      fwd_prefetch_o   <= 1'b0;
    end else begin
      fwd_done_o       <= fwd_valid_i;
      fwd_downstream_o <= fwd_valid_i && (mem_hit || pf_hit);
      fwd_prefetch_o   <= fwd_valid_i && pf_hit;
    end
  end

  // ==========================================================================
  // Checks.

  sequence s_read_status;
    cfg_valid_i && !cfg_write_i && cfg_dw == DW_STATUS;
  endsequence

  sequence s_read_mem;
    cfg_valid_i && !cfg_write_i && cfg_dw == DW_MEM;
  endsequence

  sequence s_read_pf;
    cfg_valid_i && !cfg_write_i && cfg_dw == DW_PF;
  endsequence

  sequence s_full_write(logic [5:0] dw);
    cfg_valid_i && cfg_write_i && cfg_byte_en_i == 4'hF && cfg_dw == dw;
  endsequence

  a_error_bits_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    s_read_status |=> cfg_ack_o && cfg_rdata_o[31:27] == 5'h00 && !cfg_rdata_o[24])
    else $error("secondary status error bit read as one");

  a_timing_field_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    s_read_status |=> cfg_rdata_o[26:25] == 2'h0)
    else $error("secondary status select timing not zero");

  a_capability_bits_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    s_read_status |=> !cfg_rdata_o[23] && !cfg_rdata_o[21])
    else $error("secondary status capability bit read as one");

  // A read one idle cycle after a full write must show what the write left behind.
  a_status_write_ignored: assert property (@(posedge clk_i) disable iff (reset_i)
    s_full_write(DW_STATUS) ##2 s_read_status |=>
      cfg_rdata_o == 32'h00000000)
    else $error("secondary status changed by a write");

  a_base_write_taken: assert property (@(posedge clk_i) disable iff (reset_i)
    s_full_write(DW_MEM) ##2 s_read_mem |=>
      cfg_rdata_o[15:4] == $past(cfg_wdata_i[15:4], 3))
    else $error("memory base field did not take the write");

  a_limit_write_taken: assert property (@(posedge clk_i) disable iff (reset_i)
    s_full_write(DW_MEM) ##2 s_read_mem |=>
      cfg_rdata_o[31:20] == $past(cfg_wdata_i[31:20], 3))
    else $error("memory limit field did not take the write");

  a_low_nibble_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    s_read_mem |=> cfg_rdata_o[3:0] == 4'h0 && cfg_rdata_o[19:16] == 4'h0)
    else $error("memory base or limit low nibble not zero");

  a_inside_forwarded: assert property (@(posedge clk_i) disable iff (reset_i)
    fwd_valid_i && fwd_addr_i[63:32] == 32'h00000000 &&
      window_bottom_field <= window_top_field &&
      fwd_addr_i[31:20] >= window_bottom_field &&
      fwd_addr_i[31:20] <= window_top_field |=> fwd_done_o && fwd_downstream_o)
    else $error("address inside memory window not forwarded");

  a_prefetch_base_write: assert property (@(posedge clk_i) disable iff (reset_i)
    s_full_write(DW_PF) |=> prefetch_bottom_field == $past(cfg_wdata_i[15:4]))
    else $error("prefetch base field did not take the write");

  a_wide_code_read: assert property (@(posedge clk_i) disable iff (reset_i)
    s_read_pf |=> cfg_rdata_o[3:0] == 4'h1 && cfg_rdata_o[19:16] == 4'h1)
    else $error("prefetch wide address code not reported");

  a_upper_base_write: assert property (@(posedge clk_i) disable iff (reset_i)
    s_full_write(DW_PF_UPPER) |=> prefetch_bottom_upper == $past(cfg_wdata_i))
    else $error("prefetch upper base did not take the write");

  a_closed_window: assert property (@(posedge clk_i) disable iff (reset_i)
    fwd_valid_i && window_bottom_field > window_top_field && !pf_hit |=>
      !fwd_downstream_o)
    else $error("closed memory window forwarded a transaction");

  a_prefetch_upper_miss: assert property (@(posedge clk_i) disable iff (reset_i)
    fwd_valid_i && prefetch_bottom_upper != 32'h00000000 && !mem_hit |=>
      !fwd_prefetch_o && !fwd_downstream_o)
    else $error("prefetch hit with base above 4 GB and 32-bit limit");

endmodule

//--- design/bmw_window_match.sv
// Address window comparator used for the forwarding decision.
`timescale 1ns/10ps
module bmw_window_match
  import bmw_pkg::*;
(
  // Window bounds.
  input  wire logic [63:0] base_i,
  input  wire logic [63:0] limit_i,
  // Address under test.
  input  wire logic [63:0] addr_i,
  // Result.
  output logic             hit_o
);

  // A hit needs an open window and the address inside both bounds.
  always_comb begin
    hit_o = (base_i <= limit_i) && (addr_i >= base_i) && (addr_i <= limit_i);
  end

endmodule

//--- tb/bmw_host.sv
// Host model that issues configuration accesses and forwarding lookups.
`timescale 1ns/10ps
module bmw_host (
  // Clock.
  input  wire logic        clk_i,
  // Configuration access towards the registers.
  output logic             cfg_valid_o,
  output logic             cfg_write_o,
  output logic [7:0]       cfg_addr_o,
  output logic [3:0]       cfg_byte_en_o,
  output logic [31:0]      cfg_wdata_o,
  input  wire logic        cfg_ack_i,
  input  wire logic [31:0] cfg_rdata_i,
  // Forwarding lookup.
  output logic             fwd_valid_o,
  output logic [63:0]      fwd_addr_o,
  input  wire logic        fwd_done_i,
  input  wire logic        fwd_downstream_i,
  input  wire logic        fwd_prefetch_i
);
  // ==========================================================================
  // Idle values from time zero.
  initial begin
    cfg_valid_o   = 1'b0;
    cfg_write_o   = 1'b0;
    cfg_addr_o    = 8'h00;
    cfg_byte_en_o = 4'h0;
    cfg_wdata_o   = 32'h00000000;
    fwd_valid_o   = 1'b0;
    fwd_addr_o    = 64'h0000000000000000;
  end

  // One access; ok is set only when the answer comes one cycle after the request.
  task automatic cfg_access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                            input logic [31:0] wdata, output logic [31:0] rdata,
                            output logic ok);
    int n;
    @(posedge clk_i);
    #1;
    cfg_valid_o   = 1'b1;
    cfg_write_o   = wr;
    cfg_addr_o    = addr;
    cfg_byte_en_o = be;
    cfg_wdata_o   = wdata;
    @(posedge clk_i);
    #1;
    cfg_valid_o = 1'b0;
    // Released lines show a changed value so stale data cannot pass.
    cfg_addr_o  = ~cfg_addr_o;
    cfg_wdata_o = ~cfg_wdata_o;
    n = 0;
    while (cfg_ack_i !== 1'b1 && n < 4) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    ok    = (n == 0) && (cfg_ack_i === 1'b1);
    rdata = cfg_rdata_i;
  endtask

  // One lookup; returns done, downstream and prefetch one cycle after the request.
  task automatic fwd_lookup(input logic [63:0] addr, output logic [2:0] res);
    @(posedge clk_i);
    #1;
    fwd_valid_o = 1'b1;
    fwd_addr_o  = addr;
    @(posedge clk_i);
    #1;
    fwd_valid_o = 1'b0;
    fwd_addr_o  = ~fwd_addr_o;
    res = {fwd_done_i, fwd_downstream_i, fwd_prefetch_i};
  endtask
endmodule

//--- tb/testbench.sv
// Self-checking testbench for the bridge memory window registers.
`timescale 1ns/10ps
module testbench;
  logic        clk;
  logic        reset_i;
  logic        cfg_valid, cfg_write, cfg_ack, fwd_valid, fwd_done, fwd_down, fwd_pf;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [63:0] fwd_addr;
  int          fails = 0;
  int          checks_done = 0;
  logic [63:0] la [8] = '{64'h0FFFFFFF, 64'h10000000, 64'h1FFFFFFF, 64'h20000000,
                          64'h30000000, 64'h3FFFFFFF, 64'h40000000, 64'h110000000};
  logic [1:0]  le [8] = '{2'h0, 2'h2, 2'h2, 2'h0, 2'h3, 2'h3, 2'h0, 2'h0};

  // ==========================================================================
  // Clock of 100 ns period.
  initial clk = 1'b0;
  always #50 clk = ~clk;

  bmw_regs i_dut (.clk_i(clk), .reset_i(reset_i), .cfg_valid_i(cfg_valid),
    .cfg_write_i(cfg_write), .cfg_addr_i(cfg_addr), .cfg_byte_en_i(cfg_be),
    .cfg_wdata_i(cfg_wdata), .cfg_ack_o(cfg_ack), .cfg_rdata_o(cfg_rdata),
    .fwd_valid_i(fwd_valid), .fwd_addr_i(fwd_addr), .fwd_done_o(fwd_done),
    .fwd_downstream_o(fwd_down), .fwd_prefetch_o(fwd_pf));

  bmw_host i_host (.clk_i(clk), .cfg_valid_o(cfg_valid), .cfg_write_o(cfg_write),
    .cfg_addr_o(cfg_addr), .cfg_byte_en_o(cfg_be), .cfg_wdata_o(cfg_wdata),
    .cfg_ack_i(cfg_ack), .cfg_rdata_i(cfg_rdata), .fwd_valid_o(fwd_valid),
    .fwd_addr_o(fwd_addr), .fwd_done_i(fwd_done), .fwd_downstream_i(fwd_down),
    .fwd_prefetch_i(fwd_pf));

  // ==========================================================================
  // Compares one value and reports a difference.
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Reads a dword and checks the answer and its timing.
  task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    logic        ok;
    i_host.cfg_access(1'b0, addr, 4'hF, 32'h00000000, d, ok);
    chk({63'h0, ok}, 64'h1);
    chk({32'h0, d}, {32'h0, exp});
  endtask

  // Writes a dword; a write answers with zero data.
  task automatic wr(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] v);
    logic [31:0] d;
    logic        ok;
    i_host.cfg_access(1'b1, addr, be, v, d, ok);
    chk({63'h0, ok}, 64'h1);
    chk({32'h0, d}, 64'h0);
  endtask

  // Looks up an address and checks both decisions.
  task automatic fw(input logic [63:0] a, input logic [1:0] e);
    logic [2:0] r;
    i_host.fwd_lookup(a, r);
    chk({61'h0, r}, {61'h0, 1'b1, e});
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Register values right after a reset.
  task automatic reset_values;
    rd(8'h1C, 32'h00000000);
    rd(8'h20, 32'h00000000);
    rd(8'h24, 32'h00010001);
    rd(8'h28, 32'h00000000);
  endtask

  // ==========================================================================
  // Watchdog cuts a hang short after 5000 cycles.
  initial begin
    #500000;
    fails++;
    summarize();
  end

  // Main sequence.
  initial begin
    reset_i = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    reset_i = 1'b0;
    reset_values();
    rd(8'h2C, 32'h00000000);
    wr(8'h1C, 4'hF, 32'hFFFFFFFF);
    rd(8'h1C, 32'h00000000);
    wr(8'h20, 4'hF, 32'hFFFFFFFF);
    rd(8'h20, 32'hFFF0FFF0);
    wr(8'h20, 4'h1, 32'h00000000);
    rd(8'h20, 32'hFFF0FF00);
    wr(8'h24, 4'hF, 32'hFFFFFFFF);
    rd(8'h24, 32'hFFF1FFF1);
    wr(8'h28, 4'hF, 32'h12345678);
    rd(8'h28, 32'h12345678);
    // Memory window 1000_0000..1FFF_FFFF, prefetch window 3000_0000..3FFF_FFFF.
    wr(8'h20, 4'hF, 32'h1FF01000);
    wr(8'h24, 4'hF, 32'h3FF03000);
    wr(8'h28, 4'hF, 32'h00000000);
    for (int i = 0; i < 8; i++) begin
      fw(la[i], le[i]);
    end
    // An upper base above the limit closes the prefetch window.
    wr(8'h28, 4'hF, 32'h00000001);
    fw(64'h30000000, 2'h0);
    fw(64'h130000000, 2'h0);
    // A base above the limit closes the memory window.
    wr(8'h20, 4'hF, 32'h10002000);
    fw(64'h18000000, 2'h0);
    fw(64'h20000000, 2'h0);
    // Reset in mid-run restores every field.
    @(posedge clk);
    #1;
    reset_i = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    reset_i = 1'b0;
    reset_values();
    summarize();
  end
endmodule
